// ---- rtl/solenoid_pkg.sv ----
// Behaviour
// - A rising enable input, driven or pulled up, starts an activation.
// - Activation regulates at the peak reference for the keep time, then hold.
// - Hold regulation continues while enable stays high and no lockout or overtemperature is present.
// - Enable low stops switching and holds the gate drive low.
// - The keep ramp rises linearly; at 100 mV the reference switches to hold.
// - Each on-cycle starts on a PWM tick; gate high while sense below reference.
// - Sense above reference drops the gate once the minimum on-time has run out, until the next tick.
// - Every on-cycle not cut short by a fault or by enable low keeps the gate high for at least the minimum on-time.
// - A grounded peak-setting input selects the internal default peak reference.
// - Setting resistance below 33.33 kOhm clamps to 300 mV peak, 50 mV hold.
// - Without a hold-setting input, hold reference is fixed at 50 mV.
// - External hold level is one sixth of the peak level; settings independent.
// - Grounded rate input gives default PWM rate; otherwise inverse to resistance.
// - Gate drive is high through the on portion and low in the off portion.
// - Open-drain fault flag pulls low normally, releases on lockout or overtemperature.
// - Three states: OFF, PEAK until keep time ends, HOLD until enable falls; a fault or enable low sends PEAK or HOLD to OFF.
// - Minimum on-time is 7.5 percent of the period; duty may reach 100 percent.
// - Gate switching begins within 50 us of enable rising at 20 kHz.
package solenoid_pkg;
    // ****************************************************************
    // Register map, byte addresses.
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PEAK_RES = 8'h04;
    localparam logic [7:0] ADDR_HOLD_RES = 8'h08;
    localparam logic [7:0] ADDR_RATE_RES = 8'h0c;
    localparam logic [7:0] ADDR_KEEP_SLOPE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // Control field positions.
    localparam int CTRL_PEAK_EXT = 0;
    localparam int CTRL_HOLD_EXT = 1;
    localparam int CTRL_RATE_EXT = 2;
    localparam int CTRL_HOLD_PIN = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // Resistances are held in units of 10 ohm.
    localparam logic [15:0] RES_RESET = 16'h4e20;
    localparam logic [15:0] RES_CLAMP = 16'h0d05;
    localparam logic [15:0] RES_SATURATE = 16'h1a0b;
    // Reference levels in mV.
    localparam logic [9:0] VPEAK_DEFAULT_MV = 10'h12c;
    localparam logic [9:0] VPEAK_MAX_MV = 10'h384;
    localparam logic [9:0] VHOLD_DEFAULT_MV = 10'h032;
    localparam logic [9:0] VHOLD_MAX_MV = 10'h096;
    localparam logic [31:0] PEAK_NUM = 32'h005b8e6c;
    localparam int HOLD_DIVISOR = 6;
    // Keep ramp in nV; threshold is 100 mV, reset slope gives 100 ms.
    localparam logic [31:0] KEEP_THRESHOLD_NV = 32'h05f5e100;
    localparam logic [31:0] KEEP_SLOPE_RESET = 32'h00000019;
    // PWM timing.
    localparam int PCLK_HZ = 40000000;
    localparam int PWM_DEFAULT_HZ = 20000;
    localparam int PWM_DEFAULT_CYCLES = PCLK_HZ / PWM_DEFAULT_HZ;
    localparam logic [31:0] RATE_NUM = 32'h00009c40;
    localparam logic [31:0] RATE_DEN = 32'h00061a94;
    localparam int MINIMUM_ON_FRACTION_NUM = 3;
    localparam int MINIMUM_ON_FRACTION_DEN = 40;
    localparam int STARTUP_DELAY_US = 50;
    localparam int STARTUP_DELAY_CYCLES = STARTUP_DELAY_US * (PCLK_HZ / 1000000);

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_PEAK = 3'b010,
        ST_HOLD = 3'b100
    } ctl_state_t;
endpackage : solenoid_pkg

// ---- rtl/solenoid_peak_hold_pwm_controller.sv ----
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module solenoid_peak_hold_pwm_controller #(
    parameter int PERIOD_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enable_pin,
    input wire logic supply_low_lockout,
    input wire logic thermal_shutdown,
    input wire logic [9:0] sense_mv,
    output logic gate_drive,
    output logic fault_flag_o,
    output logic fault_flag_oe,
    output logic cycle_trigger_clock
);
    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic en_prev_q;
    logic en_s;
    logic fault_s;
    logic en_rise;

    // Enable, lockout and shutdown arrive asynchronously, so each passes two flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
            en_prev_q <= 1'b0;
        end else if (ce) begin
            pin_meta_q <= {thermal_shutdown, supply_low_lockout, enable_pin};
            pin_sync_q <= pin_meta_q;
            en_prev_q <= pin_sync_q[0];
        end
    end

    assign en_s = pin_sync_q[0];
    assign fault_s = pin_sync_q[1] | pin_sync_q[2];
    assign en_rise = en_s & ~en_prev_q;

    // ****************************************************************
    // APB register file.
    // ****************************************************************
    logic [3:0] ctrl_q;
    logic [15:0] peak_res_q;
    logic [15:0] hold_res_q;
    logic [15:0] rate_res_q;
    logic [31:0] keep_slope_q;
    logic acc_done;
    logic addr_ok;
    logic [31:0] rd_d;
    solenoid_pkg::ctl_state_t state_q;
    logic [9:0] vref_q;

    assign acc_done = psel & penable & pready;

    always_comb begin
        addr_ok = 1'b1;
        rd_d = 32'h0;
        case (paddr)
            solenoid_pkg::ADDR_CTRL: rd_d = {28'h0, ctrl_q};
            solenoid_pkg::ADDR_PEAK_RES: rd_d = {16'h0, peak_res_q};
            solenoid_pkg::ADDR_HOLD_RES: rd_d = {16'h0, hold_res_q};
            solenoid_pkg::ADDR_RATE_RES: rd_d = {16'h0, rate_res_q};
            solenoid_pkg::ADDR_KEEP_SLOPE: rd_d = keep_slope_q;
            solenoid_pkg::ADDR_STATUS: rd_d = {16'h0, vref_q, fault_s, gate_drive, 1'b0, state_q};
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle, so the answer is registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel & penable & ~pready;
            prdata <= (psel & penable & ~pready & ~pwrite) ? rd_d : 32'h0;
            pslverr <= psel & penable & ~pready & ~addr_ok;
        end
    end

    // Writes take effect at the edge that completes the access; status is read only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= solenoid_pkg::CTRL_RESET;
            peak_res_q <= solenoid_pkg::RES_RESET;
            hold_res_q <= solenoid_pkg::RES_RESET;
            rate_res_q <= solenoid_pkg::RES_RESET;
            keep_slope_q <= solenoid_pkg::KEEP_SLOPE_RESET;
        end else if (ce && acc_done && pwrite) begin
            case (paddr)
                solenoid_pkg::ADDR_CTRL: ctrl_q <= pwdata[3:0];
                solenoid_pkg::ADDR_PEAK_RES: peak_res_q <= pwdata[15:0];
                solenoid_pkg::ADDR_HOLD_RES: hold_res_q <= pwdata[15:0];
                solenoid_pkg::ADDR_RATE_RES: rate_res_q <= pwdata[15:0];
                solenoid_pkg::ADDR_KEEP_SLOPE: keep_slope_q <= pwdata;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Reference and period derivation.
    // ****************************************************************
    logic [31:0] peak_calc;
    logic [31:0] hold_calc;
    logic [31:0] rate_calc;
    logic [9:0] vpeak;
    logic [9:0] vhold;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] min_on;

    // The divides are combinational; settings change rarely, so area was traded for simplicity.
    always_comb begin
        peak_calc = solenoid_pkg::PEAK_NUM / {16'h0, (peak_res_q == 16'h0) ? 16'h1 : peak_res_q};
        hold_calc = solenoid_pkg::PEAK_NUM / {16'h0, (hold_res_q == 16'h0) ? 16'h1 : hold_res_q};
        hold_calc = hold_calc / 32'(solenoid_pkg::HOLD_DIVISOR);
        if (!ctrl_q[solenoid_pkg::CTRL_PEAK_EXT] || peak_res_q < solenoid_pkg::RES_CLAMP) begin
            vpeak = solenoid_pkg::VPEAK_DEFAULT_MV;
        end else if (peak_res_q < solenoid_pkg::RES_SATURATE) begin
            vpeak = solenoid_pkg::VPEAK_MAX_MV;
        end else begin
            vpeak = peak_calc[9:0];
        end
        if (!ctrl_q[solenoid_pkg::CTRL_HOLD_PIN] || !ctrl_q[solenoid_pkg::CTRL_HOLD_EXT]) begin
            vhold = solenoid_pkg::VHOLD_DEFAULT_MV;
        end else if (hold_res_q < solenoid_pkg::RES_CLAMP) begin
            vhold = solenoid_pkg::VHOLD_DEFAULT_MV;
        end else if (hold_res_q < solenoid_pkg::RES_SATURATE) begin
            vhold = solenoid_pkg::VHOLD_MAX_MV;
        end else begin
            vhold = hold_calc[9:0];
        end
        // Below the valid range the rate is held at its highest setting.
        rate_calc = ({16'h0, (rate_res_q < solenoid_pkg::RES_SATURATE) ? solenoid_pkg::RES_SATURATE : rate_res_q}
            * solenoid_pkg::RATE_NUM) / solenoid_pkg::RATE_DEN;
        if (!ctrl_q[solenoid_pkg::CTRL_RATE_EXT]) begin
            period = PERIOD_W'(solenoid_pkg::PWM_DEFAULT_CYCLES);
        end else begin
            period = rate_calc[PERIOD_W-1:0];
        end
        min_on = PERIOD_W'((32'(period) * solenoid_pkg::MINIMUM_ON_FRACTION_NUM + solenoid_pkg::MINIMUM_ON_FRACTION_DEN - 1)
            / solenoid_pkg::MINIMUM_ON_FRACTION_DEN);
    end

    // ****************************************************************
    // State machine and keep ramp.
    // ****************************************************************
    logic [31:0] keep_ramp_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= solenoid_pkg::ST_OFF;
            keep_ramp_q <= 32'h0;
        end else if (ce) begin
            case (state_q)
                solenoid_pkg::ST_OFF: begin
                    keep_ramp_q <= 32'h0;
                    if (en_rise && !fault_s) begin
                        state_q <= solenoid_pkg::ST_PEAK;
                    end
                end
                solenoid_pkg::ST_PEAK: begin
                    keep_ramp_q <= keep_ramp_q + keep_slope_q;
                    if (fault_s || !en_s) begin
                        state_q <= solenoid_pkg::ST_OFF;
                    end else if (en_rise) begin
                        keep_ramp_q <= 32'h0;
                    end else if (keep_ramp_q >= solenoid_pkg::KEEP_THRESHOLD_NV) begin
                        state_q <= solenoid_pkg::ST_HOLD;
                    end
                end
                solenoid_pkg::ST_HOLD: begin
                    if (fault_s || !en_s) begin
                        state_q <= solenoid_pkg::ST_OFF;
                    end
                end
                default: state_q <= solenoid_pkg::ST_OFF;
            endcase
        end
    end

    // Active reference follows the state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vref_q <= solenoid_pkg::VPEAK_DEFAULT_MV;
        end else if (ce) begin
            vref_q <= (state_q == solenoid_pkg::ST_HOLD) ? vhold : vpeak;
        end
    end

    // ****************************************************************
    // PWM clock and gate drive.
    // ****************************************************************
    logic [PERIOD_W-1:0] pwm_cnt_q;
    logic [PERIOD_W-1:0] on_cnt_q;
    logic tick;
    logic running;

    assign running = (state_q != solenoid_pkg::ST_OFF) && en_s && !fault_s;
    assign tick = running && (pwm_cnt_q == '0);

    // The counter sits at zero while off, so the first tick comes right after activation.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_q <= '0;
            cycle_trigger_clock <= 1'b0;
        end else if (ce) begin
            if (!running) begin
                pwm_cnt_q <= '0;
            end else if (tick) begin
                pwm_cnt_q <= period - PERIOD_W'(1);
            end else begin
                pwm_cnt_q <= pwm_cnt_q - PERIOD_W'(1);
            end
            cycle_trigger_clock <= tick;
        end
    end

    // Gate is set only by a tick, so a dropped gate cannot return inside the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_drive <= 1'b0;
            on_cnt_q <= '0;
        end else if (ce) begin
            if (!running) begin
                gate_drive <= 1'b0;
                on_cnt_q <= '0;
            end else if (tick) begin
                gate_drive <= 1'b1;
                on_cnt_q <= min_on;
            end else if (on_cnt_q > PERIOD_W'(1)) begin
                on_cnt_q <= on_cnt_q - PERIOD_W'(1);
            end else begin
                on_cnt_q <= '0;
                if (sense_mv > vref_q) begin
                    gate_drive <= 1'b0;
                end
            end
        end
    end

    // Open-drain fault flag: pulls low while healthy, released on a fault.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_flag_o <= 1'b0;
            fault_flag_oe <= 1'b0;
        end else if (ce) begin
            fault_flag_o <= 1'b0;
            fault_flag_oe <= ~fault_s;
        end
    end
endmodule : solenoid_peak_hold_pwm_controller

// ---- sim/solenoid_load.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Load model: switch, solenoid coil and sense resistor.
// ****************************************************************
module solenoid_load (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic gate_drive,
    input wire logic overload,
    input wire logic en_oe,
    input wire logic en_val,
    output logic enable_pin,
    output logic [9:0] sense_mv
);
    // A released enable driver leaves the pull-up in charge of the line.
    assign enable_pin = en_oe ? en_val : 1'b1;
    // Current ramps while the switch conducts and decays through the diode; a short pins it high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_mv <= 10'h000;
        end else if (overload) begin
            sense_mv <= 10'h3e8;
        end else if (gate_drive && sense_mv < 10'h3e6) begin
            sense_mv <= sense_mv + 10'h002;
        end else if (!gate_drive && sense_mv != 10'h000) begin
            sense_mv <= sense_mv - 10'h001;
        end
    end
endmodule : solenoid_load

// ---- sim/solenoid_asserts.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the peak and hold controller.
// ****************************************************************
module solenoid_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic enable_pin,
    input wire logic supply_low_lockout,
    input wire logic thermal_shutdown,
    input wire logic [9:0] sense_mv,
    input wire logic gate_drive,
    input wire logic fault_flag_o,
    input wire logic fault_flag_oe,
    input wire logic cycle_trigger_clock
);
    // Minimum on-time at the default 2000-cycle period, rounded up.
    localparam int MIN_ON = 150;
    logic [15:0] on_cnt_q;
    logic any_fault;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign any_fault = supply_low_lockout || thermal_shutdown;
    // Length of the current on portion; a fault or disable cuts it short legally.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_cnt_q <= 16'h0000;
        end else if (gate_drive) begin
            on_cnt_q <= on_cnt_q + 16'h0001;
        end else begin
            on_cnt_q <= 16'h0000;
        end
    end
    a_apb_wait: assert property (psel && penable && !pready && ce |=> pready)
        else $error("APB answer missing after one wait state");
    a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    a_fault_gate: assert property (any_fault [*5] |-> !gate_drive)
        else $error("gate driven during a fault");
    a_flag_release: assert property (any_fault [*5] |-> !fault_flag_oe)
        else $error("fault flag not released");
    a_flag_pull: assert property (!any_fault [*5] |-> fault_flag_oe && !fault_flag_o)
        else $error("fault flag not pulled low");
    a_disable_off: assert property (!enable_pin [*5] |-> !gate_drive)
        else $error("gate driven while disabled");
    a_min_on: assert property (enable_pin [*6] ##0 ($fell(gate_drive) && fault_flag_oe) |-> on_cnt_q >= MIN_ON)
        else $error("on portion shorter than minimum");
    a_drop_exceed: assert property (gate_drive && sense_mv > 10'h384 && on_cnt_q >= MIN_ON |-> ##[0:2] !gate_drive)
        else $error("gate not dropped on overcurrent");
    a_tick_start: assert property ($rose(gate_drive) |-> cycle_trigger_clock)
        else $error("on portion not started by a tick");
    a_startup_time: assert property ($rose(enable_pin) && fault_flag_oe |-> ##[1:20] (gate_drive || !enable_pin))
        else $error("switching late after enable");
endmodule : solenoid_checker
bind solenoid_peak_hold_pwm_controller solenoid_checker u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .enable_pin(enable_pin),
    .supply_low_lockout(supply_low_lockout), .thermal_shutdown(thermal_shutdown), .sense_mv(sense_mv),
    .gate_drive(gate_drive), .fault_flag_o(fault_flag_o), .fault_flag_oe(fault_flag_oe),
    .cycle_trigger_clock(cycle_trigger_clock));

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Register-driven bench for the peak and hold controller.
// ****************************************************************
module tb_top;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic en_oe, en_val, overload, enable_pin, supply_low_lockout, thermal_shutdown;
    logic gate_drive, fault_flag_o, fault_flag_oe, cycle_trigger_clock;
    logic [9:0] sense_mv;
    logic [15:0] res_tab [3] = '{16'h1388, 16'h2710, 16'h0bb8};
    logic [9:0] mv_tab [3] = '{10'd900, 10'd600, 10'd300};
    int failures, checks, n;
    solenoid_peak_hold_pwm_controller DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enable_pin(enable_pin), .supply_low_lockout(supply_low_lockout),
        .thermal_shutdown(thermal_shutdown), .sense_mv(sense_mv), .gate_drive(gate_drive),
        .fault_flag_o(fault_flag_o), .fault_flag_oe(fault_flag_oe), .cycle_trigger_clock(cycle_trigger_clock));
    solenoid_load u_load (.pclk(pclk), .presetn(presetn), .gate_drive(gate_drive), .overload(overload),
        .en_oe(en_oe), .en_val(en_val), .enable_pin(enable_pin), .sense_mv(sense_mv));
    // 40 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    // One APB transfer; entered just after a rising edge, leaves one idle cycle so strobes never collide.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // Outputs are looked at mid-cycle, where they have settled after the launching edge.
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) failures++;
        rd = prdata;
        er = pslverr;
        // The edge that samples pready high completes the access; only then is the request released.
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
        check(nm, {31'h0, er}, {31'h0, eexp});
    endtask : rchk
    // Status holds state, fault and active reference; the reference shows the peak level while off and is not checked then.
    task automatic st(input string nm, input logic [2:0] s, input logic f, input logic [9:0] v);
        apb(1'b0, solenoid_pkg::ADDR_STATUS, 32'h0);
        check(nm, {18'h0, (s == 3'b001) ? 10'h0 : rd[15:6], rd[5], rd[2:0]}, {18'h0, v, f, s});
    endtask : st
    // Cycles between two ticks of the PWM clock.
    task automatic tick_gap(output int g);
        g = 0;
        while (cycle_trigger_clock !== 1'b1 && g < 5000) begin
            @(posedge pclk);
            g++;
        end
        g = 0;
        do begin
            @(posedge pclk);
            g++;
        end while (cycle_trigger_clock !== 1'b1 && g < 5000);
    endtask : tick_gap
    // A hang cannot outlast about three and a half times the expected run.
    initial begin
        repeat (90000) @(posedge pclk);
        failures++;
        final_report();
    end
    initial begin
        {ce, psel, penable, pwrite, paddr, pwdata, presetn, failures, checks} = '0;
        {en_oe, en_val, overload, supply_low_lockout, thermal_shutdown} = 5'b10000;
        ce = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rchk("ctrl", solenoid_pkg::ADDR_CTRL, 32'h0, 1'b0);
        rchk("peak_res", solenoid_pkg::ADDR_PEAK_RES, 32'h4e20, 1'b0);
        rchk("hold_res", solenoid_pkg::ADDR_HOLD_RES, 32'h4e20, 1'b0);
        rchk("rate_res", solenoid_pkg::ADDR_RATE_RES, 32'h4e20, 1'b0);
        rchk("slope", solenoid_pkg::ADDR_KEEP_SLOPE, 32'h19, 1'b0);
        rchk("unmapped", 8'h18, 32'h0, 1'b1);
        apb(1'b1, solenoid_pkg::ADDR_STATUS, 32'hffff);
        st("idle", 3'b001, 1'b0, 10'h0);
        // A 5000 nV slope reaches 100 mV after 20000 cycles.
        apb(1'b1, solenoid_pkg::ADDR_KEEP_SLOPE, 32'h1388);
        en_oe <= 1'b0;
        repeat (10) @(posedge pclk);
        st("peak", 3'b010, 1'b0, 10'd300);
        tick_gap(n);
        check("period", n, 2000);
        apb(1'b1, solenoid_pkg::ADDR_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, solenoid_pkg::ADDR_PEAK_RES, {16'h0, res_tab[i]});
            st("peak ext", 3'b010, 1'b0, mv_tab[i]);
        end
        repeat (17000) @(posedge pclk);
        st("hold", 3'b100, 1'b0, 10'd50);
        apb(1'b1, solenoid_pkg::ADDR_CTRL, 32'hb);
        apb(1'b1, solenoid_pkg::ADDR_HOLD_RES, 32'h2710);
        st("hold ext", 3'b100, 1'b0, 10'd100);
        apb(1'b1, solenoid_pkg::ADDR_HOLD_RES, 32'h0bb8);
        st("hold clamp", 3'b100, 1'b0, 10'd50);
        overload <= 1'b1;
        repeat (4000) @(posedge pclk);
        overload <= 1'b0;
        st("overload", 3'b100, 1'b0, 10'd50);
        en_oe <= 1'b1;
        repeat (10) @(posedge pclk);
        st("disabled", 3'b001, 1'b0, 10'h0);
        en_oe <= 1'b0;
        repeat (10) @(posedge pclk);
        st("restart", 3'b010, 1'b0, 10'd300);
        for (int i = 0; i < 2; i++) begin
            {supply_low_lockout, thermal_shutdown} <= (i == 0) ? 2'b10 : 2'b01;
            repeat (10) @(posedge pclk);
            st("fault", 3'b001, 1'b1, 10'h0);
            check("flag", {31'h0, fault_flag_oe}, 32'h0);
            {supply_low_lockout, thermal_shutdown} <= 2'b00;
            repeat (10) @(posedge pclk);
            check("flag", {31'h0, fault_flag_oe}, 32'h1);
        end
        final_report();
    end
endmodule : tb_top
